// *** hdl/ppm_pkg.sv ***
// package: register map, field layout and mode codes for the port-2 pin mode block
package ppm_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  // printed offset is not a multiple of four: kept as an index, byte address is four times it
  localparam logic [7:0] PPM_ACCESS_IDX = 8'h97;
  localparam logic [9:0] PPM_ACCESS_ADDR = {PPM_ACCESS_IDX, 2'b00};
  localparam int PPM_ADDR_W = 10;
  localparam logic [7:0] PPM_ACCESS_RESET = 8'h00;

  // ----------------------------------------
  // field layout
  // ----------------------------------------
  localparam int PPM_MODE_HI = 7;
  localparam int PPM_MODE_LO = 5;
  localparam int PPM_IN_MODE_HI = 6;
  localparam int PPM_DIR_BIT = 4;
  localparam int PPM_RPL_BIT = 3;
  localparam int PPM_IDX_HI = 2;
  localparam int PPM_IDX_LO = 0;

  // ----------------------------------------
  // mode codes
  // ----------------------------------------
  localparam logic [2:0] PPM_OUT_NORMAL = 3'h0;
  localparam logic [2:0] PPM_OUT_HIGH = 3'h3;
  localparam logic [1:0] PPM_IN_NOPULL = 2'h0;
  localparam logic [1:0] PPM_IN_PULLDN = 2'h1;
  localparam logic [1:0] PPM_IN_PULLUP = 2'h2;
  localparam logic [1:0] PPM_IN_OFF = 2'h3;
  localparam logic [2:0] PPM_OUT_RESET = 3'h0;
  localparam logic [1:0] PPM_IN_RESET = 2'h0;

  typedef enum logic [1:0] {
    PPM_IDLE = 2'b00,
    PPM_ACK = 2'b01
  } ppm_state_type;

endpackage : ppm_pkg

// *** hdl/ppm_port2_pin_mode.sv ***
// module: port-2 pin mode storage with indirect wishbone access
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// RULE_01 - Output mode is the three-bit mode field, 000 for normal drive and 011 for high drive.
// RULE_02 - Software writes only the two defined output codes; other codes are illegal for outputs.
// RULE_03 - Input mode uses the low two mode bits: 00 no pulls, 01 pull-down, 10 pull-up.
// RULE_04 - A stored input code of 11 switches that pin's input buffer off.
// RULE_05 - On a configuration write, direction bit 0 targets output mode and 1 targets input mode.
// RULE_06 - A write with the read-pointer-load bit set stores the pin index and direction for reads.
// RULE_07 - A write with the read-pointer-load bit set leaves all pin modes unchanged.
// RULE_08 - A write with the read-pointer-load bit clear updates the addressed pin's chosen mode.
// RULE_09 - A read returns in the mode field the mode of the stored pin and stored direction.
// RULE_10 - The three-bit pin index selects pin 0 through pin 7 directly.
// RULE_11 - The stored read pointer holds across configuration writes and resets to zero.
module ppm_port2_pin_mode #(
  parameter int PINS = 8
) (
  input wire logic ref_clk, // system clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write enable
  input wire logic [ppm_pkg::PPM_ADDR_W-1:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  output logic [PINS*3-1:0] out_mode_o, // per-pin output mode code
  output logic [PINS*2-1:0] in_mode_o, // per-pin input mode code
  output logic [PINS-1:0] out_high_drive_o, // per-pin high drive select
  output logic [PINS-1:0] in_buf_en_o, // per-pin input buffer enable
  output logic [PINS-1:0] pull_down_o, // per-pin pull-down enable
  output logic [PINS-1:0] pull_up_o // per-pin pull-up enable
);
  import ppm_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [2:0] out_mode_r [PINS];
  logic [1:0] in_mode_r [PINS];
  logic [2:0] rd_index_r;
  logic rd_dir_r;
  ppm_state_type state_r;
  logic req;
  logic hit;
  logic wr_en;
  logic [7:0] wbyte;
  logic [2:0] wr_idx;
  logic [2:0] rd_mode;
  logic [2:0] wr_mode;
  logic [1:0] wr_in_code;
  logic wr_dir;
  logic wr_rpl;
  logic cfg_wr;
  logic ptr_wr;
  logic rd_en;
  logic [PINS-1:0] pin_sel;
  ppm_state_type state_nxt;
  logic ack_nxt;
  logic [31:0] rd_data_nxt;
  logic [2:0] rd_index_nxt;
  logic rd_dir_nxt;
  logic [2:0] out_mode_nxt [PINS];
  logic [1:0] in_mode_nxt [PINS];
  logic [PINS-1:0] high_drive_nxt;
  logic [PINS-1:0] buf_en_nxt;
  logic [PINS-1:0] pull_down_nxt;
  logic [PINS-1:0] pull_up_nxt;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  assign req = wb_cyc_i && wb_stb_i && (state_r == PPM_IDLE);
  assign hit = (wb_adr_i == PPM_ACCESS_ADDR);
  assign wbyte = wb_dat_i[7:0];
  assign wr_en = req && hit && wb_we_i && wb_sel_i[0];
  // RULE_10 direct pin index
  assign wr_idx = wbyte[PPM_IDX_HI:PPM_IDX_LO];
  assign wr_dir = wbyte[PPM_DIR_BIT];
  assign wr_rpl = wbyte[PPM_RPL_BIT];
  assign wr_mode = wbyte[PPM_MODE_HI:PPM_MODE_LO];
  // RULE_03 input code in low two bits
  assign wr_in_code = wbyte[PPM_IN_MODE_HI:PPM_MODE_LO];
  // RULE_07 pointer loads never reach storage
  assign cfg_wr = wr_en && !wr_rpl;
  assign ptr_wr = wr_en && wr_rpl;
  assign rd_en = req && hit && !wb_we_i;

  // RULE_10 one-hot pin select
  genvar s;
  generate
    for (s = 0; s < PINS; s++) begin : g_sel
      assign pin_sel[s] = (wr_idx == 3'(s));
    end
  endgenerate

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // RULE_09 selected mode readback
  always_comb begin
    rd_mode = 3'h0;
    if (rd_dir_r) begin
      rd_mode = {1'b0, in_mode_r[rd_index_r]};
    end else begin
      rd_mode = out_mode_r[rd_index_r];
    end
  end

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  // one-cycle ack, dropped in the following cycle
  always_comb begin
    state_nxt = state_r;
    ack_nxt = 1'b0;
    case (state_r)
      PPM_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          state_nxt = PPM_ACK;
          ack_nxt = 1'b1;
        end
      end
      PPM_ACK: begin
        state_nxt = PPM_IDLE;
        ack_nxt = 1'b0;
      end
      default: begin
        state_nxt = PPM_IDLE;
        ack_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_r <= PPM_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= ack_nxt;
    end
  end

  // read data; unmapped addresses and write cycles read zero
  always_comb begin
    rd_data_nxt = 32'h0000_0000;
    if (rd_en) begin
      rd_data_nxt = {24'h00_0000, rd_mode, 5'h00};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_dat_o <= rd_data_nxt;
    end
  end

  // ----------------------------------------
  // read pointer
  // ----------------------------------------
  // RULE_06 store pointer on a load write
  always_comb begin
    rd_index_nxt = rd_index_r;
    rd_dir_nxt = rd_dir_r;
    if (ptr_wr) begin
      rd_index_nxt = wr_idx;
      rd_dir_nxt = wr_dir;
    end
  end

  // RULE_11 pointer reset and hold
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rd_index_r <= 3'h0;
    end else begin
      rd_index_r <= rd_index_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rd_dir_r <= 1'b0;
    end else begin
      rd_dir_r <= rd_dir_nxt;
    end
  end

  // ----------------------------------------
  // per-pin mode storage and decode
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      // RULE_08 RULE_05 direction selects target
      always_comb begin
        out_mode_nxt[g] = out_mode_r[g];
        in_mode_nxt[g] = in_mode_r[g];
        if (cfg_wr && pin_sel[g]) begin
          if (wr_dir) begin
            in_mode_nxt[g] = wr_in_code;
          end else begin
            // RULE_01 three bits for output
            out_mode_nxt[g] = wr_mode;
          end
        end
      end

      always_ff @(posedge ref_clk) begin
        if (!nrst) begin
          out_mode_r[g] <= PPM_OUT_RESET;
        end else begin
          out_mode_r[g] <= out_mode_nxt[g];
        end
      end

      always_ff @(posedge ref_clk) begin
        if (!nrst) begin
          in_mode_r[g] <= PPM_IN_RESET;
        end else begin
          in_mode_r[g] <= in_mode_nxt[g];
        end
      end

      // ----------------------------------------
      // pad controls
      // ----------------------------------------
      always_comb begin
        // RULE_01 high drive code
        high_drive_nxt[g] = (out_mode_r[g] == PPM_OUT_HIGH);
        // RULE_04 input buffer off
        buf_en_nxt[g] = (in_mode_r[g] != PPM_IN_OFF);
        // RULE_03 pull selection
        pull_down_nxt[g] = (in_mode_r[g] == PPM_IN_PULLDN);
        pull_up_nxt[g] = (in_mode_r[g] == PPM_IN_PULLUP);
      end

      // registered pad controls, one cycle behind storage
      always_ff @(posedge ref_clk) begin
        if (!nrst) begin
          out_mode_o[g*3 +: 3] <= PPM_OUT_RESET;
        end else begin
          out_mode_o[g*3 +: 3] <= out_mode_r[g];
        end
      end

      always_ff @(posedge ref_clk) begin
        if (!nrst) begin
          in_mode_o[g*2 +: 2] <= PPM_IN_RESET;
        end else begin
          in_mode_o[g*2 +: 2] <= in_mode_r[g];
        end
      end

      always_ff @(posedge ref_clk) begin
        if (!nrst) begin
          out_high_drive_o[g] <= 1'b0;
        end else begin
          out_high_drive_o[g] <= high_drive_nxt[g];
        end
      end

      always_ff @(posedge ref_clk) begin
        if (!nrst) begin
          in_buf_en_o[g] <= 1'b1;
        end else begin
          in_buf_en_o[g] <= buf_en_nxt[g];
        end
      end

      always_ff @(posedge ref_clk) begin
        if (!nrst) begin
          pull_down_o[g] <= 1'b0;
        end else begin
          pull_down_o[g] <= pull_down_nxt[g];
        end
      end

      always_ff @(posedge ref_clk) begin
        if (!nrst) begin
          pull_up_o[g] <= 1'b0;
        end else begin
          pull_up_o[g] <= pull_up_nxt[g];
        end
      end
    end
  endgenerate

endmodule : ppm_port2_pin_mode

`default_nettype wire

// *** test/ppm_checker_sva.sv ***
// checker: bus and pin-mode assertions for the port-2 pin mode block
`timescale 1ns/1ns
`default_nettype none
module ppm_checker #(parameter int PINS = 8) (
  input wire logic ref_clk, // clock
  input wire logic nrst, // reset
  input wire logic wb_cyc_i, // cyc
  input wire logic wb_stb_i, // stb
  input wire logic wb_we_i, // we
  input wire logic [ppm_pkg::PPM_ADDR_W-1:0] wb_adr_i, // adr
  input wire logic [3:0] wb_sel_i, // sel
  input wire logic [31:0] wb_dat_i, // wdata
  input wire logic [31:0] wb_dat_o, // rdata
  input wire logic wb_ack_o, // ack
  input wire logic [PINS*3-1:0] out_mode_o, // out codes
  input wire logic [PINS*2-1:0] in_mode_o, // in codes
  input wire logic [PINS-1:0] out_high_drive_o, // drive
  input wire logic [PINS-1:0] in_buf_en_o, // buffer
  input wire logic [PINS-1:0] pull_down_o, // pull-down
  input wire logic [PINS-1:0] pull_up_o // pull-up
);
  import ppm_pkg::*;
  logic tk, cw;
  logic [PINS-1:0] hd, be, pd, pu;
  assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign cw = tk && wb_we_i && wb_sel_i[0] && wb_adr_i == PPM_ACCESS_ADDR && !wb_dat_i[PPM_RPL_BIT];
  always_comb begin
    for (int g = 0; g < PINS; g++) begin
      hd[g] = out_mode_o[3*g +: 3] == PPM_OUT_HIGH;
      be[g] = in_mode_o[2*g +: 2] != PPM_IN_OFF;
      pd[g] = in_mode_o[2*g +: 2] == PPM_IN_PULLDN;
      pu[g] = in_mode_o[2*g +: 2] == PPM_IN_PULLUP;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_ack_answer: assert property (tk |=> wb_ack_o) else $error("no ack after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("read data outside ack");
  a_out_write: assert property (cw && !wb_dat_i[4] |-> ##2
    out_mode_o[3*$past(wb_dat_i[2:0], 2) +: 3] == $past(wb_dat_i[7:5], 2)) else $error("output mode not stored");
  a_in_write: assert property (cw && wb_dat_i[4] |-> ##2
    in_mode_o[2*$past(wb_dat_i[2:0], 2) +: 2] == $past(wb_dat_i[6:5], 2)) else $error("input mode not stored");
  a_rpl_keeps: assert property (tk && wb_we_i && wb_dat_i[3] |-> ##2
    $stable(out_mode_o) && $stable(in_mode_o)) else $error("pointer load changed a mode");
  a_high_drive: assert property (out_high_drive_o == hd) else $error("drive select wrong");
  a_buf_off: assert property (in_buf_en_o == be) else $error("input buffer enable wrong");
  a_pull_map: assert property ({pull_up_o, pull_down_o} == {pu, pd}) else $error("pull enables wrong");
  c_cfg_write: cover property (cw);
  c_ptr_load: cover property (tk && wb_we_i && wb_dat_i[3]);
  c_read: cover property (tk && !wb_we_i);
endmodule : ppm_checker
`default_nettype wire

// *** test/testbench.sv ***
// testbench: bus-driven checks of the port-2 pin mode block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import ppm_pkg::*;
  localparam int PINS = 8;
  logic ref_clk = 1'b0, nrst = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [3:0] wb_sel_i = 4'h1;
  logic [9:0] wb_adr_i = 10'h000;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
  logic [23:0] out_mode_o;
  logic [15:0] in_mode_o;
  logic [7:0] out_high_drive_o, in_buf_en_o, pull_down_o, pull_up_o;
  int mismatches = 0, total_checks = 0;
  always #4 ref_clk = ~ref_clk;
  ppm_port2_pin_mode #(.PINS(PINS)) dut_u (.ref_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .out_mode_o, .in_mode_o, .out_high_drive_o, .in_buf_en_o, .pull_down_o, .pull_up_o);
  task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h00_0000, d};
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk);
  endtask : wb
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (2000) @(posedge ref_clk);
    mismatches++;
    report_and_stop;
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    wb(1'b0, PPM_ACCESS_ADDR, 8'h00);
    chk(q, 32'h0000_0000);
    chk(in_buf_en_o, 8'hff);
    for (int g = 0; g < 8; g++) begin
      wb(1'b1, PPM_ACCESS_ADDR, {g[0] ? 3'h3 : 3'h0, 5'(g)});
      wb(1'b1, PPM_ACCESS_ADDR, {1'b0, g[1:0], 2'b10, g[2:0]});
    end
    chk({pull_up_o, pull_down_o, in_buf_en_o, out_high_drive_o}, 32'h4422_77aa);
    chk({8'h00, out_mode_o}, 32'h0061_8618);
    chk({16'h0000, in_mode_o}, 32'h0000_e4e4);
    for (int g = 0; g < 8; g++) begin
      for (int d = 0; d < 2; d++) begin
        wb(1'b1, PPM_ACCESS_ADDR, {3'h7, d[0], 1'b1, g[2:0]});
        wb(1'b0, PPM_ACCESS_ADDR, 8'h00);
        chk(q, {24'h00_0000, (d == 1) ? {1'b0, g[1:0]} : (g[0] ? 3'h3 : 3'h0), 5'h00});
      end
    end
    chk({pull_up_o, pull_down_o, in_buf_en_o, out_high_drive_o}, 32'h4422_77aa);
    wb(1'b1, PPM_ACCESS_ADDR, 8'h07);
    wb(1'b0, PPM_ACCESS_ADDR, 8'h00);
    chk(q, 32'h0000_0060);
    wb(1'b1, 10'h000, 8'h67);
    wb(1'b0, 10'h000, 8'h00);
    chk(q, 32'h0000_0000);
    chk(out_high_drive_o, 8'h2a);
    chk({8'h00, out_mode_o}, 32'h0001_8618);
    report_and_stop;
  end
endmodule : testbench
bind ppm_port2_pin_mode ppm_checker #(.PINS(PINS)) chk_u (.ref_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .out_mode_o, .in_mode_o, .out_high_drive_o, .in_buf_en_o, .pull_down_o,
  .pull_up_o);
`default_nettype wire
